// *** design/pamx_pkg.sv ***
// Constants, register map and carrier types for the port A alternate-function mux.
// Assumes a single system clock and an AHB-Lite register bus with 32-bit data.
//
// What this block does
// [R1] Crystal enabled: bits 0 and 1 drop GPIO settings and are released to the crystal.
// [R2] Larger packages take the external clock from port B bit 3 when selected.
// [R3] Bit 1 pairs: 00 timer0 out, 01 reserved, 10 clock in, 11 analog.
// [R4] Bit 0 pairs: 00 timer0 in, 11 timer0 inverted out; 01 and 10 reserved.
// [R5] Bit 2 pairs: 00 UART driver enable, 01 reset in, 10 timer1 out; 11 reserved.
// [R6] Bit 3 pairs: 00 UART clear-to-send, 01 comparator out, 10 timer1 in, 11 analog.
// [R7] Bit 4: 00 UART receive, 11 analog; bit 5: 00 transmit, 01 inverted timer1, 11 analog.
// [R8] Software enables a pin's alternate path besides writing its select pair.
// [R9] Reserved select pairs connect nothing and leave the pin under GPIO settings.
// [R10] All select pairs read 00 after reset.
package pamx_pkg;

	// ==============================
	// Register byte addresses
	localparam logic [7:0] PAMX_GPIO_OUT_ADDR = 8'h00;
	localparam logic [7:0] PAMX_GPIO_DIR_ADDR = 8'h04;
	localparam logic [7:0] PAMX_ALT_EN_ADDR = 8'h08;
	localparam logic [7:0] PAMX_SEL_FIRST_ADDR = 8'h0C;
	localparam logic [7:0] PAMX_SEL_SECOND_ADDR = 8'h10;
	localparam logic [7:0] PAMX_OSC_CTL_ADDR = 8'h14;
	localparam logic [7:0] PAMX_PIN_IN_ADDR = 8'h18;
	localparam logic [7:0] PAMX_RSV_STAT_ADDR = 8'h1C;

	// ==============================
	// Field positions and reset values
	localparam int PAMX_NPINS = 6;
	localparam int PAMX_OSC_XTAL_EN = 0;
	localparam int PAMX_OSC_EXT_SEL = 1;
	localparam int PAMX_OSC_LARGE_PKG = 2;
	localparam int PAMX_OSC_PB3_EXT_CLOCK_INPUT = 3;
	localparam int PAMX_OSC_W = 4;
	localparam logic [5:0] PAMX_PINS_RST = 6'h00;
	localparam logic [3:0] PAMX_OSC_RST = 4'h0;
	localparam logic [1:0] PAMX_HTRANS_NONSEQ = 2'h2;

	// ==============================
	// Select pair codes {first, second}
	localparam logic [1:0] PAMX_SEL_00 = 2'h0;
	localparam logic [1:0] PAMX_SEL_01 = 2'h1;
	localparam logic [1:0] PAMX_SEL_10 = 2'h2;
	localparam logic [1:0] PAMX_SEL_11 = 2'h3;

	// ==============================
	// Carriers
	typedef struct packed {
		logic timer0_output;
		logic timer1_output;
		logic uart_driver_enable;
		logic uart_transmit_line;
		logic comparator_output;
	} pamx_from_periph_t;

	typedef struct packed {
		logic timer0_input;
		logic timer1_input;
		logic uart_receive_line;
		logic uart_clear_to_send;
		logic ext_reset_n;
		logic ext_clock_input;
	} pamx_to_periph_t;

	localparam pamx_to_periph_t PAMX_TO_PERIPH_IDLE = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

endpackage

// *** design/pamx_top.sv ***
// Port A alternate-function mux with AHB-Lite register slave.
// Assumes pin and peripheral inputs are synchronous to clk; pin wires resolved outside.
`timescale 1ns/1ns
module pamx_top
	import pamx_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Port A pins
	input wire logic [5:0] pin_in,
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe_n,
	// Port B bit 3 input
	input wire logic portb_bit3,
	// Peripherals
	input wire pamx_from_periph_t from_periph,
	output pamx_to_periph_t to_periph,
	output logic [5:0] analog_connect,
	output logic xtal_connect
);

	// ==============================
	// Registers
	logic [5:0] gpio_out_ff, nxt_gpio_out;
	logic [5:0] gpio_dir_ff, nxt_gpio_dir;
	logic [5:0] alt_en_ff, nxt_alt_en;
	logic [5:0] alt_select_first_ff, nxt_alt_select_first;
	logic [5:0] alt_select_second_ff, nxt_alt_select_second;
	logic [3:0] osc_ff, nxt_osc;
	logic [5:0] rsv_ff, nxt_rsv;
	logic wr_pend_ff, nxt_wr_pend;
	logic [7:0] wr_addr_ff, nxt_wr_addr;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic hreadyout_ff;
	logic hresp_ff;
	logic addr_ok;
	logic take;

	assign take = hsel && hready && htrans == PAMX_HTRANS_NONSEQ;
	assign addr_ok = haddr[31:8] == 24'h000000;

	always_comb begin
		nxt_wr_pend = take && hwrite && addr_ok;
		nxt_wr_addr = wr_pend_ff ? wr_addr_ff : 8'h00;
		if (take) begin
			nxt_wr_addr = haddr[7:0];
		end
		nxt_gpio_out = gpio_out_ff;
		nxt_gpio_dir = gpio_dir_ff;
		nxt_alt_en = alt_en_ff;
		nxt_alt_select_first = alt_select_first_ff;
		nxt_alt_select_second = alt_select_second_ff;
		nxt_osc = osc_ff;
		if (wr_pend_ff) begin
			case (wr_addr_ff)
				PAMX_GPIO_OUT_ADDR: nxt_gpio_out = hwdata[5:0];
				PAMX_GPIO_DIR_ADDR: nxt_gpio_dir = hwdata[5:0];
				PAMX_ALT_EN_ADDR: nxt_alt_en = hwdata[5:0];
				PAMX_SEL_FIRST_ADDR: nxt_alt_select_first = hwdata[5:0];
				PAMX_SEL_SECOND_ADDR: nxt_alt_select_second = hwdata[5:0];
				PAMX_OSC_CTL_ADDR: nxt_osc = hwdata[3:0];
				default: nxt_osc = osc_ff;
			endcase
		end
		nxt_hrdata = hrdata_ff;
		if (take && !hwrite) begin
			nxt_hrdata = 32'h00000000;
			if (addr_ok) begin
				case (haddr[7:0])
					PAMX_GPIO_OUT_ADDR: nxt_hrdata = {26'h0000000, gpio_out_ff};
					PAMX_GPIO_DIR_ADDR: nxt_hrdata = {26'h0000000, gpio_dir_ff};
					PAMX_ALT_EN_ADDR: nxt_hrdata = {26'h0000000, alt_en_ff};
					PAMX_SEL_FIRST_ADDR: nxt_hrdata = {26'h0000000, alt_select_first_ff};
					PAMX_SEL_SECOND_ADDR: nxt_hrdata = {26'h0000000, alt_select_second_ff};
					PAMX_OSC_CTL_ADDR: nxt_hrdata = {28'h0000000, osc_ff};
					PAMX_PIN_IN_ADDR: nxt_hrdata = {26'h0000000, pin_in};
					PAMX_RSV_STAT_ADDR: nxt_hrdata = {26'h0000000, rsv_ff};
					default: nxt_hrdata = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			gpio_out_ff <= PAMX_PINS_RST;
			gpio_dir_ff <= PAMX_PINS_RST;
			alt_en_ff <= PAMX_PINS_RST;
			alt_select_first_ff <= PAMX_PINS_RST; // R10
			alt_select_second_ff <= PAMX_PINS_RST; // R10
			osc_ff <= PAMX_OSC_RST;
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff <= 32'h00000000;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end else begin
			gpio_out_ff <= nxt_gpio_out;
			gpio_dir_ff <= nxt_gpio_dir;
			alt_en_ff <= nxt_alt_en;
			alt_select_first_ff <= nxt_alt_select_first;
			alt_select_second_ff <= nxt_alt_select_second;
			osc_ff <= nxt_osc;
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			hrdata_ff <= nxt_hrdata;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end
	end

	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;
	assign hrdata = hrdata_ff;

	// ==============================
	// Pin routing
	logic [5:0] out_ff, nxt_out;
	logic [5:0] oe_n_ff, nxt_oe_n;
	logic [5:0] analog_ff, nxt_analog;
	logic xtal_ff, nxt_xtal;
	pamx_to_periph_t to_periph_ff, nxt_to_periph;
	logic [1:0] code [6];
	logic pa1_clk;
	logic xtal_on;

	assign xtal_on = osc_ff[PAMX_OSC_XTAL_EN];

	always_comb begin
		for (int i = 0; i < PAMX_NPINS; i++) begin
			code[i] = {alt_select_first_ff[i], alt_select_second_ff[i]};
		end
		nxt_out = gpio_out_ff;
		nxt_oe_n = ~gpio_dir_ff;
		nxt_analog = 6'h00;
		nxt_rsv = 6'h00;
		nxt_to_periph = PAMX_TO_PERIPH_IDLE;
		pa1_clk = 1'b0;
		// Pin 0
		if (alt_en_ff[0]) begin // R8
			case (code[0])
				PAMX_SEL_00: begin // R4
					nxt_oe_n[0] = 1'b1;
					nxt_to_periph.timer0_input = pin_in[0];
				end
				PAMX_SEL_11: begin // R4
					nxt_oe_n[0] = 1'b0;
					nxt_out[0] = ~from_periph.timer0_output;
				end
				default: nxt_rsv[0] = 1'b1; // R9
			endcase
		end
		// Pin 1
		if (alt_en_ff[1]) begin
			case (code[1])
				PAMX_SEL_00: begin // R3
					nxt_oe_n[1] = 1'b0;
					nxt_out[1] = from_periph.timer0_output;
				end
				PAMX_SEL_10: begin // R3
					nxt_oe_n[1] = 1'b1;
					pa1_clk = 1'b1;
				end
				PAMX_SEL_11: begin // R3
					nxt_oe_n[1] = 1'b1;
					nxt_analog[1] = 1'b1;
				end
				default: nxt_rsv[1] = 1'b1; // R9
			endcase
		end
		// Pin 2
		if (alt_en_ff[2]) begin
			case (code[2])
				PAMX_SEL_00: begin // R5
					nxt_oe_n[2] = 1'b0;
					nxt_out[2] = from_periph.uart_driver_enable;
				end
				PAMX_SEL_01: begin // R5
					nxt_oe_n[2] = 1'b1;
					nxt_to_periph.ext_reset_n = pin_in[2];
				end
				PAMX_SEL_10: begin // R5
					nxt_oe_n[2] = 1'b0;
					nxt_out[2] = from_periph.timer1_output;
				end
				default: nxt_rsv[2] = 1'b1; // R9
			endcase
		end
		// Pin 3
		if (alt_en_ff[3]) begin
			case (code[3])
				PAMX_SEL_00: begin // R6
					nxt_oe_n[3] = 1'b1;
					nxt_to_periph.uart_clear_to_send = pin_in[3];
				end
				PAMX_SEL_01: begin // R6
					nxt_oe_n[3] = 1'b0;
					nxt_out[3] = from_periph.comparator_output;
				end
				PAMX_SEL_10: begin // R6
					nxt_oe_n[3] = 1'b1;
					nxt_to_periph.timer1_input = pin_in[3];
				end
				default: begin // R6
					nxt_oe_n[3] = 1'b1;
					nxt_analog[3] = 1'b1;
				end
			endcase
		end
		// Pin 4
		if (alt_en_ff[4]) begin
			case (code[4])
				PAMX_SEL_00: begin // R7
					nxt_oe_n[4] = 1'b1;
					nxt_to_periph.uart_receive_line = pin_in[4];
				end
				PAMX_SEL_11: begin // R7
					nxt_oe_n[4] = 1'b1;
					nxt_analog[4] = 1'b1;
				end
				default: nxt_rsv[4] = 1'b1; // R9
			endcase
		end
		// Pin 5
		if (alt_en_ff[5]) begin
			case (code[5])
				PAMX_SEL_00: begin // R7
					nxt_oe_n[5] = 1'b0;
					nxt_out[5] = from_periph.uart_transmit_line;
				end
				PAMX_SEL_01: begin // R7
					nxt_oe_n[5] = 1'b0;
					nxt_out[5] = ~from_periph.timer1_output;
				end
				PAMX_SEL_11: begin // R7
					nxt_oe_n[5] = 1'b1;
					nxt_analog[5] = 1'b1;
				end
				default: nxt_rsv[5] = 1'b1; // R9
			endcase
		end
		// Crystal owns pins 0 and 1
		nxt_xtal = xtal_on;
		if (xtal_on) begin // R1
			nxt_oe_n[1:0] = 2'h3;
			nxt_out[1:0] = 2'h0;
			nxt_analog[1:0] = 2'h0;
			nxt_to_periph.timer0_input = 1'b0;
			pa1_clk = 1'b0;
		end
		// External clock source
		if (osc_ff[PAMX_OSC_EXT_SEL]) begin
			if (osc_ff[PAMX_OSC_LARGE_PKG]) begin // R2
				nxt_to_periph.ext_clock_input = osc_ff[PAMX_OSC_PB3_EXT_CLOCK_INPUT] & portb_bit3;
			end else begin
				nxt_to_periph.ext_clock_input = pa1_clk & pin_in[1];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			out_ff <= PAMX_PINS_RST;
			oe_n_ff <= 6'h3F;
			analog_ff <= PAMX_PINS_RST;
			xtal_ff <= 1'b0;
			rsv_ff <= PAMX_PINS_RST;
			to_periph_ff <= PAMX_TO_PERIPH_IDLE;
		end else begin
			out_ff <= nxt_out;
			oe_n_ff <= nxt_oe_n;
			analog_ff <= nxt_analog;
			xtal_ff <= nxt_xtal;
			rsv_ff <= nxt_rsv;
			to_periph_ff <= nxt_to_periph;
		end
	end

	assign pin_out = out_ff;
	assign pin_oe_n = oe_n_ff;
	assign analog_connect = analog_ff;
	assign xtal_connect = xtal_ff;
	assign to_periph = to_periph_ff;

	// ==============================
	// Assertions
	sequence sel_wr_s;
		take && hwrite && haddr == {24'h000000, PAMX_SEL_FIRST_ADDR};
	endsequence

	sequence pa4_rsv_s;
		alt_en_ff[4] && code[4] == PAMX_SEL_01;
	endsequence

	xtal_release_a: assert property (@(posedge clk) disable iff (reset) // R1
		xtal_on |=> pin_oe_n[1:0] == 2'h3 && analog_connect[1:0] == 2'h0 && xtal_connect)
		else $error("crystal pins not released");
	pb3_clock_a: assert property (@(posedge clk) disable iff (reset) // R2
		osc_ff == 4'hE |=> to_periph.ext_clock_input == $past(portb_bit3))
		else $error("port B clock not routed");
	pa1_clock_a: assert property (@(posedge clk) disable iff (reset) // R3
		osc_ff == 4'h2 && alt_en_ff[1] && code[1] == PAMX_SEL_10
		|=> to_periph.ext_clock_input == $past(pin_in[1]) && pin_oe_n[1])
		else $error("pin 1 clock not routed");
	pa0_comp_a: assert property (@(posedge clk) disable iff (reset) // R4
		!xtal_on && alt_en_ff[0] && code[0] == PAMX_SEL_11
		|=> !pin_oe_n[0] && pin_out[0] != $past(from_periph.timer0_output))
		else $error("pin 0 complement wrong");
	pa2_reset_a: assert property (@(posedge clk) disable iff (reset) // R5
		alt_en_ff[2] && code[2] == PAMX_SEL_01 |=> pin_oe_n[2] && to_periph.ext_reset_n == $past(pin_in[2]))
		else $error("reset input not routed");
	pa3_comp_a: assert property (@(posedge clk) disable iff (reset) // R6
		alt_en_ff[3] && code[3] == PAMX_SEL_01 |=> !pin_oe_n[3] && pin_out[3] == $past(from_periph.comparator_output))
		else $error("comparator not on pin 3");
	pa5_txd_a: assert property (@(posedge clk) disable iff (reset) // R7
		alt_en_ff[5] && code[5] == PAMX_SEL_00 |=> !pin_oe_n[5] && pin_out[5] == $past(from_periph.uart_transmit_line))
		else $error("transmit line not on pin 5");
	alt_gate_a: assert property (@(posedge clk) disable iff (reset) // R8
		!alt_en_ff[3] |=> pin_oe_n[3] == $past(~gpio_dir_ff[3]) && !analog_connect[3])
		else $error("pin 3 routed without enable");
	rsv_gpio_a: assert property (@(posedge clk) disable iff (reset) // R9
		pa4_rsv_s |=> pin_out[4] == $past(gpio_out_ff[4]) && pin_oe_n[4] == $past(~gpio_dir_ff[4])
		&& to_periph.uart_receive_line && rsv_ff[4])
		else $error("reserved code leaked");
	sel_reset_a: assert property (@(posedge clk) // R10
		reset |=> alt_select_first_ff == 6'h00 && alt_select_second_ff == 6'h00)
		else $error("select pairs not cleared");
	sel_write_a: assert property (@(posedge clk) disable iff (reset)
		sel_wr_s ##1 1'b1 |=> alt_select_first_ff == $past(hwdata[5:0]))
		else $error("select write lost");

endmodule

// *** test/pamx_periph_model.sv ***
// Far-side model: timer, UART and comparator output levels.
// Assumes the bench sets the levels; they reach the block one clock later.
`timescale 1ns/1ns
module pamx_periph_model
	import pamx_pkg::*;
(
	// Clock
	input wire logic clk,
	// Levels
	input wire logic [4:0] lvl,
	output pamx_from_periph_t from_periph
);
	always_ff @(posedge clk) begin
		from_periph <= lvl;
	end
endmodule

// *** test/tb_top.sv ***
// Bench for the port A alternate-function mux: registers and random routing.
// Assumes this bench is the only AHB-Lite master and hready is hreadyout.
`timescale 1ns/1ns
module tb_top;
	import pamx_pkg::*;
	// ==========
	// Signals
	logic clk, reset, hsel, hwrite, rd_dp, pb3, xt, hresp;
	wire logic hready;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, wd, ed;
	logic [5:0] pi, po, poe, an, go, gd, ae, s1, s2, en, ro, rk, re, rm, ra, rs, rsm;
	logic [4:0] lvl;
	logic [3:0] osc;
	pamx_from_periph_t fp;
	pamx_to_periph_t tp, rt, rtm;
	logic [63:0] q[$];
	int failures, n_checks;
	pamx_top i_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.pin_in(pi), .pin_out(po), .pin_oe_n(poe), .portb_bit3(pb3), .from_periph(fp), .to_periph(tp),
		.analog_connect(an), .xtal_connect(xt));
	pamx_periph_model i_per (.clk(clk), .lvl(lvl), .from_periph(fp));
	// ==========
	// Checking
	task automatic cmp(input string n, input logic [31:0] e, g, m);
		n_checks++;
		if (((g ^ e) & m) !== 32'h0) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	always @(posedge clk) begin
		if (rd_dp && hready) begin
			cmp("hrdata", q[0][31:0], hrdata, q[0][63:32]);
			cmp("hresp", 32'h0, 32'(hresp), 32'h1);
			void'(q.pop_front());
		end
	end
	task automatic finish_test();
		$display("checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ==========
	// Bus
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= PAMX_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp <= !w;
		do @(posedge clk); while (hready !== 1'b1);
		rd_dp <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		q.push_back({m, e});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic cfg();
		bus(1'b1, PAMX_GPIO_OUT_ADDR, 32'(go));
		bus(1'b1, PAMX_GPIO_DIR_ADDR, 32'(gd));
		bus(1'b1, PAMX_ALT_EN_ADDR, 32'(ae));
		bus(1'b1, PAMX_SEL_FIRST_ADDR, 32'(s1));
		bus(1'b1, PAMX_SEL_SECOND_ADDR, 32'(s2));
		bus(1'b1, PAMX_OSC_CTL_ADDR, 32'(osc));
	endtask
	// ==========
	// Expected routing
	task automatic drv(input int i, input logic v);
		ro[i] = v;
		re[i] = 1'b0;
	endtask
	task automatic rel(input int i);
		re[i] = 1'b1;
		rm[i] = 1'b1;
	endtask
	task automatic inp(input int i, input int b);
		rel(i);
		rt[b] = pi[i];
	endtask
	task automatic ana(input int i);
		ra[i] = 1'b1;
		re[i] = 1'b1;
	endtask
	task automatic route();
		rt = PAMX_TO_PERIPH_IDLE;
		rtm = '1;
		ro = go;
		re = ~gd;
		rk = '1;
		rm = '1;
		ra = '0;
		rs = '0;
		rsm = '1;
		en = ae & ~{4'h0, {2{osc[0]}}};
		for (int i = 0; i < 6; i++) begin
			if (en[i]) begin
				case ({3'(i), s1[i], s2[i]})
					5'h00: inp(0, 5);
					5'h03: drv(0, ~fp.timer0_output);
					5'h04: drv(1, fp.timer0_output);
					5'h06: rel(1);
					5'h07: ana(1);
					5'h08: drv(2, fp.uart_driver_enable);
					5'h09: inp(2, 1);
					5'h0A: drv(2, fp.timer1_output);
					5'h0C: inp(3, 2);
					5'h0D: drv(3, fp.comparator_output);
					5'h0E: inp(3, 4);
					5'h0F: ana(3);
					5'h10: inp(4, 3);
					5'h13: ana(4);
					5'h14: drv(5, fp.uart_transmit_line);
					5'h15: drv(5, ~fp.timer1_output);
					5'h17: ana(5);
					default: rs[i] = 1'b1;
				endcase
			end
		end
		if (osc[3:1] == 3'h7) rt[0] = pb3;
		else if (osc[2:1] == 2'h1 && en[1] && {s1[1], s2[1]} == 2'h2) rt[0] = pi[1];
		if (osc[0]) begin
			re[1:0] = 2'h3;
			rsm[1:0] = 2'h0;
		end
		rk = rk & ~re;
	endtask
	// ==========
	// Sequence
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#400000;
		failures++;
		finish_test();
	end
	initial begin
		reset = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		rd_dp = 1'b0;
		pi = 6'h0;
		pb3 = 1'b0;
		lvl = 5'h0;
		failures = 0;
		n_checks = 0;
		void'($urandom(29786));
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		cmp("oe_n", 32'h3F, 32'(poe), 32'h3F);
		cmp("to_periph", 32'(PAMX_TO_PERIPH_IDLE), 32'(tp), 32'h3F);
		cmp("analog", 32'h0, 32'({an, xt}), 32'h7F);
		@(posedge clk);
		for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0, '1);
		$display("test reset_values done");
		for (int a = 0; a <= 32; a += 4) begin
			wd = $urandom;
			ed = (a < 20) ? (wd & 32'h3F) : (a == 20) ? (wd & 32'hF) : (a == 24) ? 32'(pi) : 32'h0;
			bus(1'b1, 8'(a), wd);
			rd(8'(a), ed, (a == 28) ? 32'h0 : '1);
		end
		$display("test register_access done");
		repeat (60) begin
			go = 6'($urandom);
			gd = 6'($urandom);
			ae = 6'($urandom | $urandom);
			s1 = 6'($urandom);
			s2 = 6'($urandom);
			osc = 4'($urandom) & {3'h7, 1'($urandom % 3 == 0)};
			cfg();
			pi <= 6'($urandom);
			lvl <= 5'($urandom);
			pb3 <= 1'($urandom);
			repeat (4) @(posedge clk);
			@(negedge clk);
			route();
			cmp("pin_out", 32'(ro), 32'(po), 32'(rk));
			cmp("oe_n", 32'(re), 32'(poe), 32'(rm));
			cmp("analog", 32'(ra), 32'(an), 32'h3F);
			cmp("to_periph", 32'(rt), 32'(tp), 32'(rtm));
			cmp("xtal", 32'(osc[0]), 32'(xt), 32'h1);
			@(posedge clk);
			rd(PAMX_RSV_STAT_ADDR, 32'(rs), 32'(rsm));
			rd(PAMX_PIN_IN_ADDR, 32'(pi), '1);
		end
		@(posedge clk);
		$display("test random_routing done");
		finish_test();
	end
endmodule
